//--- core/shp_port.v
/*
 * Host register port: four-wire serial link or two-wire slave, chosen by
 * a strap, feeding register writes through a FIFO into the register map.
 * Assumes all pins are asynchronous to mclk and the link clocks are
 * slow enough (a few mclk per half period) to be sampled and edge found.
 */
// What this block does
// - strap low selects the four-wire serial link, mode 1.
// - serial data output released whenever chip select is high.
// - frame starts at chip select low; sixteen bits sampled on falling edge.
// - top two bits: 00 writes or direct command, 01 reads.
// - six address bits follow the mode bits.
// - read frame shifts the addressed register out after the address.
// - holding chip select low keeps reading incremented addresses.
// - writing 0x96 to 0x3C restores all register defaults.
// - writing 0x96 to 0x3D starts oscillator calibration.
// - strap high selects the two-wire slave.
// - slave address is 00000, two strap bits, then direction bit.
// - two-wire write takes pointer then data bytes, pointer advancing.
// - after read address the byte at the pointer is sent at once.
// - two-wire reads continue while the master acks, pointer advancing per byte.
`timescale 1ns/1ps
`default_nettype none
`include "shp_map.vh"

module shp_port #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire mclk,
    input  wire resetn,
    input  wire interface_select,
    input  wire slave_addr_strap_low,
    input  wire slave_addr_strap_high,
    input  wire spi_cs_n,
    input  wire spi_sclk,
    input  wire spi_mosi,
    output wire spi_miso_out,
    output wire spi_miso_oe,
    input  wire twowire_clock_pin,
    input  wire twowire_data_pin_in,
    output wire twowire_data_pin_out,
    output wire twowire_data_pin_oe,
    output wire oscillator_trim_start
);
    localparam AW = `SHP_ADDR_W;
    localparam DW = `SHP_DATA_W;
    localparam FW = AW + DW;

    localparam [2:0] I_IDLE  = 3'h0;
    localparam [2:0] I_ADDR  = 3'h1;
    localparam [2:0] I_PTR   = 3'h2;
    localparam [2:0] I_WDATA = 3'h3;
    localparam [2:0] I_ACK   = 3'h4;
    localparam [2:0] I_RDATA = 3'h5;
    localparam [2:0] I_RACK  = 3'h6;

    reg  [7:0]    sync1_reg;
    reg  [7:0]    sync2_reg;
    reg  [7:0]    prev_reg;
    reg  [3:0]    cnt_reg;
    reg  [7:0]    sreg_reg;
    reg  [1:0]    op_reg;
    reg           spi_rd_reg;
    reg  [AW-1:0] ptr_reg;
    reg  [AW-1:0] rd_addr_reg;
    reg           rd_req_reg;
    reg           ld_reg;
    reg  [DW-1:0] tx_reg;
    reg           push_valid_reg;
    reg  [FW-1:0] push_data_reg;
    reg  [2:0]    st_reg;
    reg  [2:0]    nxt_reg;
    reg           miso_out_reg;
    reg           miso_oe_reg;
    reg           sda_oe_reg;
    reg           sda_out_reg;
    reg           trim_reg;

    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire [AW-1:0] drain_addr;
    wire [DW-1:0] drain_data;
    wire          mem_busy;
    wire [DW-1:0] mem_rd_data;
    wire          drain;
    wire          restore_hit;
    wire          trim_hit;
    wire          mem_wr;

    // bit map: 0 cs, 1 sclk, 2 mosi, 3 scl, 4 sda, 5 select, 6 a0, 7 a1
    wire cs_s      = sync2_reg[0];
    wire mosi_s    = sync2_reg[2];
    wire scl_s     = sync2_reg[3];
    wire sda_s     = sync2_reg[4];
    wire mode_i2c  = sync2_reg[5];
    wire sclk_fall = prev_reg[1] & ~sync2_reg[1];
    wire scl_rise  = ~prev_reg[3] & scl_s;
    wire scl_fall  = prev_reg[3] & ~scl_s;
    wire i2c_start = scl_s & prev_reg[3] & prev_reg[4] & ~sda_s;
    wire i2c_stop  = scl_s & prev_reg[3] & ~prev_reg[4] & sda_s;
    wire [6:0] own_addr = {`SHP_SLAVE_HI, sync2_reg[7], sync2_reg[6]};

    function cmd_match;
        input [AW-1:0] a;
        input [DW-1:0] d;
        input [AW-1:0] target;
        begin
            cmd_match = (a == target) && (d == `SHP_CMD_KEY);
        end
    endfunction

    assign spi_miso_out          = miso_out_reg;
    assign spi_miso_oe           = miso_oe_reg;
    assign twowire_data_pin_out  = sda_out_reg;
    assign twowire_data_pin_oe   = sda_oe_reg;
    assign oscillator_trim_start = trim_reg;

    // every pin, straps included, passes two flops before use
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= `SHP_SYNC_IDLE;
            sync2_reg <= `SHP_SYNC_IDLE;
            prev_reg  <= `SHP_SYNC_IDLE;
        end else begin
            sync1_reg <= {slave_addr_strap_high, slave_addr_strap_low,
                          interface_select, twowire_data_pin_in,
                          twowire_clock_pin, spi_mosi, spi_sclk, spi_cs_n};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg        <= 4'h0;
            sreg_reg       <= 8'h00;
            op_reg         <= 2'h0;
            spi_rd_reg     <= 1'b0;
            ptr_reg        <= {AW{1'b0}};
            rd_addr_reg    <= {AW{1'b0}};
            rd_req_reg     <= 1'b0;
            ld_reg         <= 1'b0;
            tx_reg         <= 8'h00;
            push_valid_reg <= 1'b0;
            push_data_reg  <= {FW{1'b0}};
            st_reg         <= I_IDLE;
            nxt_reg        <= I_IDLE;
            miso_out_reg   <= 1'b0;
            miso_oe_reg    <= 1'b0;
            sda_oe_reg     <= 1'b0;
            sda_out_reg    <= 1'b0;
        end else begin
            rd_req_reg     <= 1'b0;
            push_valid_reg <= 1'b0;
            ld_reg         <= rd_req_reg;
            if (ld_reg) begin
                tx_reg <= mem_rd_data;
            end
            if (!mode_i2c) begin
                st_reg       <= I_IDLE;
                sda_oe_reg   <= 1'b0;
                miso_oe_reg  <= ~cs_s;
                miso_out_reg <= tx_reg[7] & spi_rd_reg;
                if (cs_s) begin
                    cnt_reg    <= 4'h0;
                    spi_rd_reg <= 1'b0;
                end else if (sclk_fall) begin
                    sreg_reg <= {sreg_reg[6:0], mosi_s};
                    if (cnt_reg == `SHP_SPI_BYTE_END) begin
                        cnt_reg <= `SHP_SPI_WRAP;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (cnt_reg == `SHP_SPI_HDR_END) begin
                        op_reg  <= sreg_reg[6:5];
                        ptr_reg <= {sreg_reg[4:0], mosi_s};
                        if (sreg_reg[6:5] == `SHP_OP_READ) begin
                            spi_rd_reg  <= 1'b1;
                            rd_req_reg  <= 1'b1;
                            rd_addr_reg <= {sreg_reg[4:0], mosi_s};
                        end
                    end
                    if (spi_rd_reg && cnt_reg[3]) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                    if (cnt_reg == `SHP_SPI_BYTE_END) begin
                        ptr_reg <= ptr_reg + 1'b1;
                        if (spi_rd_reg) begin
                            rd_req_reg  <= 1'b1;
                            rd_addr_reg <= ptr_reg + 1'b1;
                        end else if (op_reg == `SHP_OP_WRITE && fifo_in_ready) begin
                            push_valid_reg <= 1'b1;
                            push_data_reg  <= {ptr_reg, sreg_reg[6:0], mosi_s};
                        end
                    end
                end
            end else begin
                miso_oe_reg  <= 1'b0;
                miso_out_reg <= 1'b0;
                spi_rd_reg   <= 1'b0;
                if (i2c_start) begin
                    st_reg     <= I_ADDR;
                    cnt_reg    <= 4'h0;
                    sda_oe_reg <= 1'b0;
                end else if (i2c_stop) begin
                    st_reg     <= I_IDLE;
                    sda_oe_reg <= 1'b0;
                end else if (scl_rise) begin
                    case (st_reg)
                        I_ADDR, I_PTR, I_WDATA: begin
                            sreg_reg <= {sreg_reg[6:0], sda_s};
                            cnt_reg  <= cnt_reg + 4'h1;
                        end
                        I_RDATA: begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                        I_RACK: begin
                            // a nack from the master ends the read
                            if (sda_s) begin
                                st_reg <= I_IDLE;
                            end else begin
                                st_reg  <= I_RDATA;
                                cnt_reg <= 4'h0;
                            end
                        end
                        default: begin
                            cnt_reg <= cnt_reg;
                        end
                    endcase
                end else if (scl_fall) begin
                    case (st_reg)
                        I_ADDR, I_PTR, I_WDATA: begin
                            if (cnt_reg == `SHP_I2C_BITS) begin
                                cnt_reg <= 4'h0;
                                st_reg  <= I_ACK;
                                if (st_reg == I_ADDR) begin
                                    if (sreg_reg[7:1] == own_addr) begin
                                        sda_oe_reg <= 1'b1;
                                        if (sreg_reg[0]) begin
                                            nxt_reg     <= I_RDATA;
                                            rd_req_reg  <= 1'b1;
                                            rd_addr_reg <= ptr_reg;
                                        end else begin
                                            nxt_reg <= I_PTR;
                                        end
                                    end else begin
                                        st_reg <= I_IDLE;
                                    end
                                end else if (st_reg == I_PTR) begin
                                    ptr_reg    <= sreg_reg[AW-1:0];
                                    sda_oe_reg <= 1'b1;
                                    nxt_reg    <= I_WDATA;
                                end else if (fifo_in_ready) begin
                                    push_valid_reg <= 1'b1;
                                    push_data_reg  <= {ptr_reg, sreg_reg};
                                    ptr_reg        <= ptr_reg + 1'b1;
                                    sda_oe_reg     <= 1'b1;
                                    nxt_reg        <= I_WDATA;
                                end else begin
                                    // buffer full: nack so the master sees the loss
                                    st_reg <= I_IDLE;
                                end
                            end
                        end
                        I_ACK: begin
                            st_reg  <= nxt_reg;
                            cnt_reg <= 4'h0;
                            if (nxt_reg == I_RDATA) begin
                                sda_oe_reg <= ~tx_reg[7];
                                tx_reg     <= {tx_reg[6:0], 1'b0};
                            end else begin
                                sda_oe_reg <= 1'b0;
                            end
                        end
                        I_RDATA: begin
                            if (cnt_reg == `SHP_I2C_BITS) begin
                                sda_oe_reg  <= 1'b0;
                                st_reg      <= I_RACK;
                                ptr_reg     <= ptr_reg + 1'b1;
                                rd_req_reg  <= 1'b1;
                                rd_addr_reg <= ptr_reg + 1'b1;
                            end else begin
                                sda_oe_reg <= ~tx_reg[7];
                                tx_reg     <= {tx_reg[6:0], 1'b0};
                            end
                        end
                        default: begin
                            sda_oe_reg <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // writes drain into the map; a restore sweep holds the buffer back
    assign drain       = fifo_out_valid & ~mem_busy;
    assign drain_addr  = fifo_out_data[FW-1:DW];
    assign drain_data  = fifo_out_data[DW-1:0];
    assign restore_hit = drain & cmd_match(drain_addr, drain_data, `SHP_RESTORE_ADR);
    assign trim_hit    = drain & cmd_match(drain_addr, drain_data, `SHP_TRIM_ADR);
    assign mem_wr      = drain && (drain_addr != `SHP_RESTORE_ADR)
                               && (drain_addr != `SHP_TRIM_ADR);

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            trim_reg <= 1'b0;
        end else begin
            trim_reg <= trim_hit;
        end
    end

    shp_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (mclk),
        .resetn    (resetn),
        .in_valid  (push_valid_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_reg),
        .out_valid (fifo_out_valid),
        .out_ready (~mem_busy),
        .out_data  (fifo_out_data)
    );

    shp_regmem #(
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clk     (mclk),
        .resetn  (resetn),
        .wr_en   (mem_wr),
        .wr_addr (drain_addr),
        .wr_data (drain_data),
        .rd_addr (rd_addr_reg),
        .rd_data (mem_rd_data),
        .restore (restore_hit),
        .busy    (mem_busy)
    );
endmodule

`default_nettype wire

//--- core/shp_map.vh
/*
 * Constants of the sensor host register port: command decode, direct
 * command addresses and key, two-wire addressing and register defaults.
 * Assumes it is included by its bare name from the core files.
 */
`ifndef SHP_MAP_VH
`define SHP_MAP_VH

`define SHP_ADDR_W      6
`define SHP_DATA_W      8
`define SHP_OP_WRITE    2'h0
`define SHP_OP_READ     2'h1
`define SHP_RESTORE_ADR 6'h3C
`define SHP_TRIM_ADR    6'h3D
`define SHP_CMD_KEY     8'h96
`define SHP_SLAVE_HI    5'h00
`define SHP_SPI_HDR_END 4'h7
`define SHP_SPI_BYTE_END 4'hF
`define SHP_SPI_WRAP    4'h8
`define SHP_I2C_BITS    4'h8
`define SHP_SYNC_IDLE   8'h19
`define SHP_DEF_00      8'h24
`define SHP_DEF_01      8'h22
`define SHP_DEF_02      8'hC2
`define SHP_DEF_ZERO    8'h00

`endif

//--- core/shp_fifo.v
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two and AW is its log2.
 */
`timescale 1ns/1ps
`default_nettype none

module shp_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    localparam [AW:0] FULL = DEPTH[AW:0];
    reg [WIDTH-1:0] store_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      count_reg;
    wire            do_push;
    wire            do_pop;

    assign in_ready  = (count_reg != FULL);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = store_reg[rd_reg];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    always @(posedge clk) begin
        if (do_push) begin
            store_reg[wr_reg] <= in_data;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg    <= {AW{1'b0}};
            rd_reg    <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

//--- core/shp_regmem.v
/*
 * Register map storage with registered read data and a default sweep.
 * Assumes writes are refused by the caller while busy is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "shp_map.vh"

module shp_regmem #(
    parameter AW = 6,
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          resetn,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data,
    input  wire          restore,
    output reg           busy
);
    reg [DW-1:0] cell_reg [0:(1<<AW)-1];
    reg [AW-1:0] sweep_reg;

    function [DW-1:0] dflt;
        input [AW-1:0] a;
        begin
            case (a)
                6'h00:   dflt = `SHP_DEF_00;
                6'h01:   dflt = `SHP_DEF_01;
                6'h02:   dflt = `SHP_DEF_02;
                default: dflt = `SHP_DEF_ZERO;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        rd_data <= cell_reg[rd_addr];
        if (busy) begin
            cell_reg[sweep_reg] <= dflt(sweep_reg);
        end else if (wr_en) begin
            cell_reg[wr_addr] <= wr_data;
        end
    end

    // the array has no reset, so defaults are written by a sweep after reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy      <= 1'b1;
            sweep_reg <= {AW{1'b0}};
        end else if (busy) begin
            sweep_reg <= sweep_reg + 1'b1;
            if (sweep_reg == {AW{1'b1}}) begin
                busy <= 1'b0;
            end
        end else if (restore) begin
            busy      <= 1'b1;
            sweep_reg <= {AW{1'b0}};
        end
    end
endmodule

`default_nettype wire

//--- test/shp_port_sva.sv
/* concurrent checks on the register port pins.
   assumes it is bound to shp_port and sees the pins on mclk. */
`timescale 1ns/1ps
`default_nettype none
module shp_port_sva (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic interface_select,
    input wire logic slave_addr_strap_low,
    input wire logic slave_addr_strap_high,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe,
    input wire logic twowire_clock_pin,
    input wire logic twowire_data_pin_in,
    input wire logic twowire_data_pin_out,
    input wire logic twowire_data_pin_oe,
    input wire logic oscillator_trim_start
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // five cycles cover the two-flop sync plus the registered enable
    a_miso_released: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    a_miso_driven: assert property ((!interface_select && !spi_cs_n) [*5] |-> spi_miso_oe)
        else $error("miso not driven while selected");
    a_miso_hold: assert property (!spi_cs_n && $fell(spi_sclk) |-> ##1 $stable(spi_miso_out) [*2])
        else $error("miso moved at the sampling edge");
    a_twowire_quiet: assert property (!interface_select [*4] |-> !twowire_data_pin_oe)
        else $error("two-wire data driven in four-wire mode");
    a_spi_quiet: assert property (interface_select [*4] |-> !spi_miso_oe)
        else $error("miso driven in two-wire mode");
    a_drain_low: assert property (twowire_data_pin_out == 1'b0)
        else $error("two-wire data output not low");
    a_sda_clock_low: assert property ($changed(twowire_data_pin_oe) |-> !twowire_clock_pin)
        else $error("two-wire data changed while clock high");
    a_trim_single: assert property (oscillator_trim_start |=> !oscillator_trim_start)
        else $error("trim pulse longer than one cycle");
    c_trim: cover property (oscillator_trim_start);
    c_spi_drive: cover property ($rose(spi_miso_oe));
    c_ack: cover property ($rose(twowire_data_pin_oe));
endmodule
bind shp_port shp_port_sva chk_u (.*);
`default_nettype wire

//--- test/shp_host.sv
/* host master model: four-wire mode 1 frames and two-wire bytes.
   assumes the bench resolves miso and the pulled-up data line. */
`timescale 1ns/1ps
`default_nettype none
module shp_host (
    input  wire logic mclk,
    input  wire logic miso,
    input  wire logic sda,
    output var  logic cs_n = 1'b1,
    output var  logic sclk = 1'b0,
    output var  logic mosi = 1'b0,
    output var  logic scl = 1'b1,
    output var  logic sda_low = 1'b0
);
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // 8 mclk per bit: 1.25MHz, under the limit and clear of 500kHz
    task spi_bits(input int n, input logic [15:0] w, output logic [7:0] r);
        cs_n <= 1'b0;
        tick(2);
        for (int i = 15; i > 15 - n; i--) begin
            sclk <= 1'b1;
            mosi <= w[i];
            tick(3);
            @(negedge mclk) r = {r[6:0], miso};
            @(posedge mclk) sclk <= 1'b0;
            tick(4);
        end
    endtask
    task spi_close(input logic rd);
        tick(6);
        cs_n <= 1'b1;
        if (rd) begin
            tick(4);
            cs_n <= 1'b0;
            tick(4);
            cs_n <= 1'b1;
        end
        tick(8);
    endtask
    // data moves only mid-way through clock low, never near an edge
    task i2c_bit(input logic b, output logic s);
        tick(2);
        sda_low <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(3);
        @(negedge mclk) s = sda;
        @(posedge mclk) scl <= 1'b0;
    endtask
    task i2c_byte(input logic [7:0] v, input logic last, output logic [7:0] r,
                  output logic a);
        for (int i = 7; i >= 0; i--)
            i2c_bit(v[i], r[i]);
        i2c_bit(last, a);
    endtask
    task i2c_start;
        tick(4);
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    task i2c_stop;
        tick(2);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(8);
    endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
/* self-checking bench for the register port over both transports.
   assumes shp_host and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        interface_select = 1'b0;
    logic        slave_addr_strap_low = 1'b0;
    logic        slave_addr_strap_high = 1'b0;
    logic        miso_last = 1'b0;
    logic        ack;
    logic [5:0]  a;
    logic [7:0]  r, dev, t0, trim_cnt = 8'h00;
    logic [7:0]  exp_mem [0:63];
    logic [15:0] rnd = 16'h9D14;
    int          miscompares = 0;
    int          checks_done = 0;
    wire         spi_cs_n, spi_sclk, spi_mosi, spi_miso_out, spi_miso_oe, sda_low;
    wire         twowire_clock_pin, twowire_data_pin_out, twowire_data_pin_oe;
    wire         oscillator_trim_start;
    // a released miso shows the inverse of its last bit, never a lucky match
    wire         miso_w = spi_miso_oe ? spi_miso_out : ~miso_last;
    wire         twowire_data_pin_in = ~(sda_low | (twowire_data_pin_oe & ~twowire_data_pin_out));

    shp_port dut_u (.*);
    shp_host host_u (.mclk(mclk), .miso(miso_w), .sda(twowire_data_pin_in), .cs_n(spi_cs_n),
        .sclk(spi_sclk), .mosi(spi_mosi), .scl(twowire_clock_pin), .sda_low(sda_low));

    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        if (spi_miso_oe)
            miso_last <= spi_miso_out;
        if (oscillator_trim_start === 1'b1)
            trim_cnt <= trim_cnt + 8'h01;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] def_val(input logic [5:0] x);
        return (x == 6'h00) ? 8'h24 : (x == 6'h01) ? 8'h22 : (x == 6'h02) ? 8'hC2 : 8'h00;
    endfunction
    task check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task spi_wr(input logic [5:0] x, input logic [7:0] d, input logic [1:0] op);
        host_u.spi_bits(16, {op, x, d}, r);
        host_u.spi_close(1'b0);
    endtask
    task spi_rd(input logic [5:0] x);
        host_u.spi_bits(16, {2'h1, x, 8'h00}, r);
        host_u.spi_close(1'b1);
    endtask
    task i2c_point(input logic [5:0] p);
        host_u.i2c_start;
        host_u.i2c_byte(dev, 1'b1, r, ack);
        check("write address ack", {7'h00, ack}, 8'h00);
        host_u.i2c_byte({2'h0, p}, 1'b1, r, ack);
        check("pointer ack", {7'h00, ack}, 8'h00);
    endtask
    task reload;
        for (int i = 0; i < 64; i++)
            exp_mem[i] = def_val(i[5:0]);
    endtask

    initial begin
        reload;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (80) @(posedge mclk);
        host_u.spi_bits(16, {2'h1, 6'h00, 8'h00}, r);
        check("burst byte 0", r, 8'h24);
        for (int i = 1; i < 4; i++) begin
            host_u.spi_bits(8, 16'h0000, r);
            check("burst byte", r, exp_mem[i]);
        end
        host_u.spi_close(1'b1);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            a = (i == 0) ? 6'h3F : (i == 1) ? 6'h20 : rnd[13:8];
            if (a[5:1] == 5'h1E)
                a = a ^ 6'h04;
            spi_wr(a, rnd[7:0], 2'h0);
            exp_mem[a] = rnd[7:0];
            spi_wr(a, ~rnd[7:0], {1'b1, i[0]});
            spi_rd(a);
            check("readback", r, exp_mem[a]);
        end
        t0 = trim_cnt;
        spi_wr(6'h3D, 8'h55, 2'h0);
        spi_wr(6'h3D, 8'h96, 2'h0);
        repeat (20) @(posedge mclk);
        check("trim pulses", trim_cnt, t0 + 8'h01);
        spi_wr(6'h3C, 8'h96, 2'h0);
        repeat (100) @(posedge mclk);
        reload;
        spi_rd(6'h00);
        check("restored 00", r, 8'h24);
        spi_rd(6'h20);
        check("restored 20", r, 8'h00);
        rnd = lfsr_next(rnd);
        slave_addr_strap_high <= rnd[1];
        slave_addr_strap_low <= rnd[0];
        interface_select <= 1'b1;
        repeat (10) @(posedge mclk);
        dev = {5'h00, slave_addr_strap_high, slave_addr_strap_low, 1'b0};
        i2c_point(6'h10);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr_next(rnd);
            host_u.i2c_byte(rnd[7:0], 1'b1, r, ack);
            check("data ack", {7'h00, ack}, 8'h00);
            exp_mem[16 + i] = rnd[7:0];
        end
        host_u.i2c_stop;
        i2c_point(6'h11);
        host_u.i2c_start;
        host_u.i2c_byte(dev | 8'h01, 1'b1, r, ack);
        check("read address ack", {7'h00, ack}, 8'h00);
        host_u.i2c_byte(8'hFF, 1'b1, r, ack);
        check("random read", r, exp_mem[17]);
        host_u.i2c_stop;
        i2c_point(6'h3F);
        host_u.i2c_stop;
        host_u.i2c_start;
        host_u.i2c_byte(dev | 8'h01, 1'b1, r, ack);
        for (int i = 0; i < 3; i++) begin
            host_u.i2c_byte(8'hFF, i == 2, r, ack);
            check("sequential read", r, exp_mem[(i + 63) % 64]);
        end
        host_u.i2c_stop;
        host_u.i2c_start;
        host_u.i2c_byte(dev ^ 8'h08, 1'b1, r, ack);
        check("foreign address", {7'h00, ack}, 8'h01);
        host_u.i2c_stop;
        t0 = trim_cnt;
        i2c_point(6'h3D);
        host_u.i2c_byte(8'h96, 1'b1, r, ack);
        host_u.i2c_stop;
        repeat (20) @(posedge mclk);
        check("two-wire trim", trim_cnt, t0 + 8'h01);
        end_of_test;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        end_of_test;
    end
endmodule
`default_nettype wire
